// ---- rtl/gen_cfg_pkg.sv ----
/*
 * Constants and carrier types for the serializer general configuration bank.
 * Assumes a host-side target that delivers decoded byte reads and writes.
 */
package gen_cfg_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_GENERAL_CONFIG        = 8'h03;
    localparam logic [7:0] ADDR_GENERAL_CONFIG_SECOND = 8'h04;
    localparam logic [7:0] ADDR_PORT_SELECT           = 8'h1E;

    // Reset values
    localparam logic [7:0] RST_GENERAL_CONFIG        = 8'h92;
    localparam logic [7:0] RST_GENERAL_CONFIG_SECOND = 8'h00;
    localparam logic [7:0] RST_PORT_SELECT           = 8'h00;
    localparam logic [7:0] READ_UNMAPPED             = 8'h00;

    // First register field positions
    localparam int BIT_CRC_CHECK_EN = 7;
    localparam int BIT_PULL_LOW_OFF = 6;
    localparam int BIT_EARLY_ACK    = 5;
    localparam int BIT_SYNC_FILTER  = 4;
    localparam int BIT_FORWARDING   = 3;
    localparam int BIT_PCLK_AUTO    = 1;

    // Second register field positions
    localparam int BIT_CRC_CLEAR    = 5;
    localparam int BIT_FWD_OVERRIDE = 1;
    localparam int BIT_FWD_OVR_VAL  = 0;

    // Port select field position
    localparam int BIT_PORT_SELECT  = 0;

    // Least pulse width, in system clock cycles, that the sync filter passes
    localparam int FILTER_MIN_CYCLES = 2;

    // Per-port private copy of the port-specific fields
    typedef struct packed {
        logic early_ack;
        logic forwarding;
        logic fwd_override;
        logic fwd_override_value;
    } port_cfg_s;

    localparam port_cfg_s PORT_CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

    // Video timing strobes
    typedef struct packed {
        logic display_enable;
        logic horiz_sync;
        logic vert_sync;
    } sync_s;

endpackage

// ---- rtl/gen_cfg_regs.sv ----
/*
 * General configuration register bank of the display bridge serializer:
 * two shared/per-port configuration registers and the port-select register.
 * Assumes the device's two-wire target delivers one-cycle read and write
 * strobes with a byte address on the system clock; the link, CRC and clock
 * switching logic consume the registered control outputs.
 */
`timescale 1ns/1ps

module gen_cfg_regs (
    // Clock and reset
    input  wire logic               CLK_SYS_IN,
    input  wire logic               RST_IN,
    // Register access from the two-wire target
    input  wire logic [7:0]         REG_ADDR_IN,
    input  wire logic [7:0]         REG_WDATA_IN,
    input  wire logic               REG_WR_IN,
    input  wire logic               REG_RD_IN,
    output logic      [7:0]         REG_RDATA_OUT,
    output logic                    REG_RVALID_OUT,
    // Remote receiver capability, one bit per link port
    input  wire logic [1:0]         REMOTE_FWD_CAP_IN,
    // Video strobes from pins
    input  wire gen_cfg_pkg::sync_s SYNC_PINS_IN,
    output gen_cfg_pkg::sync_s      SYNC_CLEAN_OUT,
    // Shared controls
    output logic                    CRC_CHECK_EN_OUT,
    output logic                    PIN_PULL_LOW_OFF_OUT,
    output logic                    PCLK_AUTO_SWITCH_OUT,
    output logic                    CRC_COUNT_CLEAR_OUT,
    // Per-port controls, bit 1 is the second port
    output logic      [1:0]         REMOTE_WRITE_EARLY_ACK_OUT,
    output logic      [1:0]         REMOTE_BUS_FORWARDING_OUT,
    output logic      [1:0]         FWD_CHECK_ENABLE_OUT
);

    logic                   crc_check_en_q;
    logic                   pull_low_off_q;
    logic                   sync_filter_q;
    logic                   pclk_auto_q;
    logic                   crc_clear_q;
    logic                   second_port_select_q;
    gen_cfg_pkg::port_cfg_s port_cfg_q [2];
    logic [1:0]             fwd_en_q;
    logic [7:0]             rdata_q;
    logic                   rvalid_q;
    logic                   wr_cfg1;
    logic                   wr_cfg2;
    logic                   wr_psel;
    logic                   sel;

    // Chosen port copy for the per-port fields
    // port copy steering
    assign sel     = second_port_select_q;
    assign wr_cfg1 = REG_WR_IN && (REG_ADDR_IN == gen_cfg_pkg::ADDR_GENERAL_CONFIG);
    assign wr_cfg2 = REG_WR_IN && (REG_ADDR_IN == gen_cfg_pkg::ADDR_GENERAL_CONFIG_SECOND);
    assign wr_psel = REG_WR_IN && (REG_ADDR_IN == gen_cfg_pkg::ADDR_PORT_SELECT);

    // Read image of the first register for one port copy
    function automatic logic [7:0] cfg1_image(input gen_cfg_pkg::port_cfg_s pc,
                                              input logic crc_en, input logic pull_off,
                                              input logic filt, input logic pauto);
        logic [7:0] v;
        v = 8'h00;
        v[gen_cfg_pkg::BIT_CRC_CHECK_EN] = crc_en;
        v[gen_cfg_pkg::BIT_PULL_LOW_OFF] = pull_off;
        v[gen_cfg_pkg::BIT_EARLY_ACK]    = pc.early_ack;
        v[gen_cfg_pkg::BIT_SYNC_FILTER]  = filt;
        v[gen_cfg_pkg::BIT_FORWARDING]   = pc.forwarding;
        v[gen_cfg_pkg::BIT_PCLK_AUTO]    = pauto;
        return v;
    endfunction

    // Read image of the second register for one port copy
    function automatic logic [7:0] cfg2_image(input gen_cfg_pkg::port_cfg_s pc,
                                              input logic clr);
        logic [7:0] v;
        v = 8'h00;
        v[gen_cfg_pkg::BIT_CRC_CLEAR]    = clr;
        v[gen_cfg_pkg::BIT_FWD_OVERRIDE] = pc.fwd_override;
        v[gen_cfg_pkg::BIT_FWD_OVR_VAL]  = pc.fwd_override_value;
        return v;
    endfunction

    // Shared fields of the first register
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            crc_check_en_q <= gen_cfg_pkg::RST_GENERAL_CONFIG[gen_cfg_pkg::BIT_CRC_CHECK_EN];
            pull_low_off_q <= gen_cfg_pkg::RST_GENERAL_CONFIG[gen_cfg_pkg::BIT_PULL_LOW_OFF];
            sync_filter_q  <= gen_cfg_pkg::RST_GENERAL_CONFIG[gen_cfg_pkg::BIT_SYNC_FILTER];
            pclk_auto_q    <= gen_cfg_pkg::RST_GENERAL_CONFIG[gen_cfg_pkg::BIT_PCLK_AUTO];
        end else if (wr_cfg1) begin
            crc_check_en_q <= REG_WDATA_IN[gen_cfg_pkg::BIT_CRC_CHECK_EN];
            pull_low_off_q <= REG_WDATA_IN[gen_cfg_pkg::BIT_PULL_LOW_OFF];
            sync_filter_q  <= REG_WDATA_IN[gen_cfg_pkg::BIT_SYNC_FILTER];
            pclk_auto_q    <= REG_WDATA_IN[gen_cfg_pkg::BIT_PCLK_AUTO];
        end
    end

    // held counter clear
    // Not self-clearing, so counters stay cleared until software writes 0
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            crc_clear_q <= gen_cfg_pkg::RST_GENERAL_CONFIG_SECOND[gen_cfg_pkg::BIT_CRC_CLEAR];
        end else if (wr_cfg2) begin
            crc_clear_q <= REG_WDATA_IN[gen_cfg_pkg::BIT_CRC_CLEAR];
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            second_port_select_q <= gen_cfg_pkg::RST_PORT_SELECT[gen_cfg_pkg::BIT_PORT_SELECT];
        end else if (wr_psel) begin
            second_port_select_q <= REG_WDATA_IN[gen_cfg_pkg::BIT_PORT_SELECT];
        end
    end

    // per-port copies
    // Only the selected copy takes the write; the other keeps its value
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            port_cfg_q[0] <= gen_cfg_pkg::PORT_CFG_RESET;
            port_cfg_q[1] <= gen_cfg_pkg::PORT_CFG_RESET;
        end else begin
            if (wr_cfg1) begin
                port_cfg_q[sel].early_ack  <= REG_WDATA_IN[gen_cfg_pkg::BIT_EARLY_ACK];
                port_cfg_q[sel].forwarding <= REG_WDATA_IN[gen_cfg_pkg::BIT_FORWARDING];
            end
            if (wr_cfg2) begin
                port_cfg_q[sel].fwd_override <= REG_WDATA_IN[gen_cfg_pkg::BIT_FWD_OVERRIDE];
                port_cfg_q[sel].fwd_override_value <=
                    REG_WDATA_IN[gen_cfg_pkg::BIT_FWD_OVR_VAL];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            fwd_en_q <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                fwd_en_q[p] <= port_cfg_q[p].fwd_override ?
                               port_cfg_q[p].fwd_override_value : REMOTE_FWD_CAP_IN[p];
            end
        end
    end

    // reserved bits zero
    // Read data registered one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            rdata_q  <= gen_cfg_pkg::READ_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_RD_IN;
            if (REG_RD_IN) begin
                case (REG_ADDR_IN)
                    gen_cfg_pkg::ADDR_GENERAL_CONFIG:
                        rdata_q <= cfg1_image(port_cfg_q[sel], crc_check_en_q,
                                              pull_low_off_q, sync_filter_q, pclk_auto_q);
                    gen_cfg_pkg::ADDR_GENERAL_CONFIG_SECOND:
                        rdata_q <= cfg2_image(port_cfg_q[sel], crc_clear_q);
                    gen_cfg_pkg::ADDR_PORT_SELECT:
                        rdata_q <= {7'h00, second_port_select_q};
                    default:
                        rdata_q <= gen_cfg_pkg::READ_UNMAPPED;
                endcase
            end
        end
    end

    sync_glitch_filter u_filter (
        .clk_in       (CLK_SYS_IN),
        .rst_in       (RST_IN),
        .filter_en_in (sync_filter_q),
        .raw_in       (SYNC_PINS_IN),
        .clean_out    (SYNC_CLEAN_OUT)
    );

    // Control outputs, each straight from a flop
    assign CRC_CHECK_EN_OUT     = crc_check_en_q;
    assign PIN_PULL_LOW_OFF_OUT = pull_low_off_q;
    assign PCLK_AUTO_SWITCH_OUT = pclk_auto_q;
    assign CRC_COUNT_CLEAR_OUT  = crc_clear_q;
    assign FWD_CHECK_ENABLE_OUT = fwd_en_q;
    assign REG_RDATA_OUT        = rdata_q;
    assign REG_RVALID_OUT       = rvalid_q;
    assign REMOTE_WRITE_EARLY_ACK_OUT = {port_cfg_q[1].early_ack, port_cfg_q[0].early_ack};
    assign REMOTE_BUS_FORWARDING_OUT  = {port_cfg_q[1].forwarding, port_cfg_q[0].forwarding};

    sequence s_cfg1_write;
        wr_cfg1;
    endsequence

    a_crc_check_wr: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> CRC_CHECK_EN_OUT
                         == $past(REG_WDATA_IN[gen_cfg_pkg::BIT_CRC_CHECK_EN]))
        else $error("Checker enable did not follow write");
    a_pull_low_wr: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> PIN_PULL_LOW_OFF_OUT
                         == $past(REG_WDATA_IN[gen_cfg_pkg::BIT_PULL_LOW_OFF]))
        else $error("Pull-down disable did not follow write");
    a_early_ack_port: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> REMOTE_WRITE_EARLY_ACK_OUT[$past(sel)]
                         == $past(REG_WDATA_IN[gen_cfg_pkg::BIT_EARLY_ACK]))
        else $error("Early ack copy did not follow write");
    a_forward_port: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> REMOTE_BUS_FORWARDING_OUT[$past(sel)]
                         == $past(REG_WDATA_IN[gen_cfg_pkg::BIT_FORWARDING]))
        else $error("Pass-through copy did not follow write");
    a_pclk_auto_wr: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> PCLK_AUTO_SWITCH_OUT
                         == $past(REG_WDATA_IN[gen_cfg_pkg::BIT_PCLK_AUTO]))
        else $error("Auto-switch did not follow write");
    a_crc_clear_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (CRC_COUNT_CLEAR_OUT && !wr_cfg2) |=> CRC_COUNT_CLEAR_OUT)
        else $error("Counter clear dropped without a write");
    a_fwd_capability: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        !port_cfg_q[0].fwd_override |=> FWD_CHECK_ENABLE_OUT[0] == $past(REMOTE_FWD_CAP_IN[0]))
        else $error("Forward check ignored capability");
    a_fwd_override: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        port_cfg_q[1].fwd_override
            |=> FWD_CHECK_ENABLE_OUT[1] == $past(port_cfg_q[1].fwd_override_value))
        else $error("Forward check ignored override value");
    a_other_port_kept: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_cfg1_write |=> REMOTE_WRITE_EARLY_ACK_OUT[!$past(sel)]
                         == $past(REMOTE_WRITE_EARLY_ACK_OUT[!sel]))
        else $error("Unselected port copy changed");
    a_psel_read: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (REG_RD_IN && REG_ADDR_IN == gen_cfg_pkg::ADDR_PORT_SELECT)
            |=> REG_RDATA_OUT == {7'h00, $past(second_port_select_q)})
        else $error("Port select read mismatch");
    a_reserved_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (REG_RD_IN && REG_ADDR_IN == gen_cfg_pkg::ADDR_GENERAL_CONFIG_SECOND)
            |=> REG_RDATA_OUT[7:6] == 2'h0 && REG_RDATA_OUT[4:2] == 3'h0)
        else $error("Reserved bits read non-zero");

endmodule // gen_cfg_regs

// ---- rtl/sync_glitch_filter.sv ----
/*
 * Glitch filter for the display-enable and sync inputs.
 * Assumes the raw inputs are asynchronous pins and the clock is the system clock.
 */
`timescale 1ns/1ps

module sync_glitch_filter (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // Control
    input  wire logic               filter_en_in,
    // Video strobes
    input  wire gen_cfg_pkg::sync_s raw_in,
    output gen_cfg_pkg::sync_s      clean_out
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] pend_q;
    logic [2:0] clean_q;

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // two-cycle filter
    // A change must be seen on two edges in a row before it passes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_q  <= 3'h0;
            clean_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!filter_en_in) begin
                    clean_q[i] <= sync_q[i];
                    pend_q[i]  <= 1'b0;
                end else if (sync_q[i] != clean_q[i]) begin
                    if (pend_q[i]) begin
                        clean_q[i] <= sync_q[i];
                        pend_q[i]  <= 1'b0;
                    end else begin
                        pend_q[i]  <= 1'b1; // Wait one more edge
                    end
                end else begin
                    pend_q[i] <= 1'b0; // One-cycle pulse is dropped
                end
            end
        end
    end

    assign clean_out = clean_q;

    a_short_pulse_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        (filter_en_in && sync_q[0] != clean_q[0] && !pend_q[0])
            |=> (clean_q[0] == $past(clean_q[0])))
        else $error("Filtered strobe changed after one cycle");

endmodule // sync_glitch_filter

// ---- testbench/host_port_model.sv ----
/*
 * Host side of the decoded register port: issues single byte writes and reads.
 * Assumes strobes are taken on the rising clock edge and read data
 * follows one cycle after the read strobe.
 */
`timescale 1ns/1ps

module host_port_model (
    // Clock
    input  wire logic       clk_in,
    // Register access toward the bank
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    // Idle values; address and data are scrambled between accesses
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // One-cycle write strobe, qualifiers held across the taking edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask

    // One-cycle read strobe, data taken while the valid pulse stands
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out   = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out   = 1'b0;
        addr_out = ~a;
        d        = rdata_in;
        ok       = rvalid_in;
    endtask
endmodule // host_port_model

// ---- testbench/test_gen_cfg_regs.sv ----
/*
 * Self-checking bench for the general configuration bank: random register
 * traffic against an integer model, counter clear hold, and sync filtering.
 * Assumes the host port model drives the register strobes.
 */
`timescale 1ns/1ps

module test_gen_cfg_regs;
    logic                clk_sys_in = 1'b0;
    logic                rst_in     = 1'b1;
    logic [1:0]          cap        = 2'h0;
    gen_cfg_pkg::sync_s  pins       = '0;
    gen_cfg_pkg::sync_s  clean;
    logic [7:0]          addr, wdata, rdata;
    logic                wr, rd, rvalid, crc_en, pull_off, pauto, crc_clr;
    logic [1:0]          early_ack, fwd_on, fwd_chk;
    int                  n_mismatch = 0;
    int                  cmp_count  = 0;
    int                  cycles     = 0;
    int                  sh3 = 'h92, clr = 0, sel = 0, i;
    int                  ea[2] = '{0, 0}, fw[2] = '{0, 0}, ov[2] = '{0, 0}, vl[2] = '{0, 0};
    logic [7:0]          a, got;
    logic                ok;
    logic [2:0]          sync_exp = 3'h0;

    // Clock at 25 MHz
    always #20 clk_sys_in = ~clk_sys_in;

    gen_cfg_regs uut (
        .CLK_SYS_IN(clk_sys_in), .RST_IN(rst_in), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .REMOTE_FWD_CAP_IN(cap), .SYNC_PINS_IN(pins), .SYNC_CLEAN_OUT(clean),
        .CRC_CHECK_EN_OUT(crc_en), .PIN_PULL_LOW_OFF_OUT(pull_off),
        .PCLK_AUTO_SWITCH_OUT(pauto), .CRC_COUNT_CLEAR_OUT(crc_clr),
        .REMOTE_WRITE_EARLY_ACK_OUT(early_ack), .REMOTE_BUS_FORWARDING_OUT(fwd_on),
        .FWD_CHECK_ENABLE_OUT(fwd_chk));

    host_port_model host (
        .clk_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Model of a host write; per-port bits land in the selected copy only
    task automatic model_write(input int ad, input int dv);
        case (ad)
            'h03: begin
                sh3     = dv & 'hD2;
                ea[sel] = (dv >> 5) & 1;
                fw[sel] = (dv >> 3) & 1;
            end
            'h04: begin
                clr     = (dv >> 5) & 1;
                ov[sel] = (dv >> 1) & 1;
                vl[sel] = dv & 1;
            end
            'h1E: sel = dv & 1;
            default: ;
        endcase
    endtask

    function automatic int exp_read(input int ad);
        case (ad)
            'h03: return sh3 | (ea[sel] << 5) | (fw[sel] << 3);
            'h04: return (clr << 5) | (ov[sel] << 1) | vl[sel];
            'h1E: return sel;
            default: return 0;
        endcase
    endfunction

    function automatic int fwd(input int p);
        return ov[p] ? vl[p] : ((cap >> p) & 1);
    endfunction

    // All control outputs against the model
    task automatic check_all();
        check("crc_en", {7'h00, crc_en}, 8'((sh3 >> 7) & 1));
        check("pull_off", {7'h00, pull_off}, 8'((sh3 >> 6) & 1));
        check("pclk_auto", {7'h00, pauto}, 8'((sh3 >> 1) & 1));
        check("crc_clear", {7'h00, crc_clr}, 8'(clr));
        check("early_ack", {6'h00, early_ack}, 8'((ea[1] << 1) | ea[0]));
        check("forwarding", {6'h00, fwd_on}, 8'((fw[1] << 1) | fw[0]));
        check("fwd_check", {6'h00, fwd_chk}, 8'((fwd(1) << 1) | fwd(0)));
    endtask

    // Write, let the two-cycle path settle, compare, then read back
    task automatic access(input logic [7:0] ad, input logic [7:0] dv);
        host.write_reg(ad, dv);
        model_write(ad, dv);
        @(posedge clk_sys_in);
        #1;
        check_all();
        host.read_reg(ad, got, ok);
        check("rvalid", {7'h00, ok}, 8'h01);
        check("readback", got, 8'(exp_read(ad)));
    endtask

    // Pin level change seen after a fixed latency, not before
    task automatic sync_edge(input logic [2:0] v, input int lat);
        pins = v;
        for (int k = 1; k <= lat; k++) begin
            @(posedge clk_sys_in);
            #1;
            check("sync_level", {5'h00, clean}, (k < lat) ? {5'h00, sync_exp} : {5'h00, v});
        end
        sync_exp = v;
    endtask

    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        void'($urandom(73));
        repeat (16) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        @(posedge clk_sys_in);
        #1;
        check_all();
        // Reset values, per port and shared
        access(8'h1E, 8'h00);
        access(8'h03, 8'h92);
        access(8'h04, 8'h00);
        // Random traffic over both ports, override on and off
        for (i = 0; i < 80; i++) begin
            case ($urandom % 4)
                0: a = 8'h03;
                1: a = 8'h04;
                2: a = 8'h1E;
                default: a = 8'($urandom);
            endcase
            cap = 2'($urandom);
            access(a, 8'($urandom));
        end
        // Counter clear holds until the host writes it back to zero
        access(8'h04, 8'h20);
        repeat (5) @(posedge clk_sys_in);
        #1;
        check("clear_hold", {7'h00, crc_clr}, 8'h01);
        // Mid-run reset: every field, the held clear and both port copies return
        rst_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        sh3 = 'h92;
        clr = 0;
        sel = 0;
        ea  = '{0, 0};
        fw  = '{0, 0};
        ov  = '{0, 0};
        vl  = '{0, 0};
        @(posedge clk_sys_in);
        #1;
        check_all();
        host.read_reg(8'h03, got, ok);
        check("reset_read", got, 8'h92);
        access(8'h04, 8'h00);
        // Filter on: one-cycle pulse rejected, held level after four cycles
        access(8'h03, 8'h92);
        pins = 3'h7;
        @(posedge clk_sys_in);
        #1;
        pins = sync_exp;
        repeat (6) begin
            @(posedge clk_sys_in);
            #1;
            check("sync_pulse", {5'h00, clean}, {5'h00, sync_exp});
        end
        sync_edge(3'h5, 4);
        sync_edge(3'h2, 4);
        // Filter off: three cycle path
        access(8'h03, 8'h82);
        sync_edge(3'h7, 3);
        sync_edge(3'($urandom), 3);
        test_done();
    end
endmodule // test_gen_cfg_regs
